// >>> mtsc_pkg.sv
package mtsc_pkg;

  // register page and word addresses of the statistics bank
  localparam logic [3:0] MTSC_MEMORY_MAP_SELECTOR = 4'h1;
  localparam logic [15:0] MTSC_DEFERRED_TX_FRAME_COUNT_ADDR = 16'h003F;
  localparam logic [15:0] MTSC_TX_CARRIER_LOSS_COUNT_ADDR = 16'h0040;
  localparam logic [15:0] MTSC_RX_BYTE_COUNT_LOW_ADDR = 16'h0041;
  localparam logic [15:0] MTSC_RX_BYTE_COUNT_HIGH_ADDR = 16'h0042;
  localparam logic [15:0] MTSC_RX_GOOD_FRAME_COUNT_ADDR = 16'h0043;

  // field widths, all fields start at bit 0
  localparam int MTSC_DEFERRED_TX_WIDTH = 18;
  localparam int MTSC_CARRIER_LOSS_WIDTH = 10;
  localparam int MTSC_RX_BYTE_WIDTH = 48;
  localparam int MTSC_RX_BYTE_LOW_WIDTH = 32;
  localparam int MTSC_RX_BYTE_HIGH_WIDTH = 16;
  localparam int MTSC_GOOD_FRAME_WIDTH = 32;
  localparam int MTSC_FIELD_LSB = 0;

  // register data and reset value
  localparam int MTSC_DATA_WIDTH = 32;
  localparam logic [31:0] MTSC_REG_RESET = 32'h0000_0000;
  localparam logic [31:0] MTSC_UNMAPPED_DATA = 32'h0000_0000;

  // width of the received frame length reported by the mac
  localparam int MTSC_FRAME_LEN_WIDTH = 16;

endpackage

// >>> mtsc_sat_counter.sv
`timescale 1ns/1ps
module mtsc_sat_counter #(
  parameter int WIDTH = 18
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic inc_i,
  input wire logic clr_i,
  // value
  output logic [WIDTH-1:0] count_o
);

  localparam logic [WIDTH-1:0] MAX_COUNT = {WIDTH{1'b1}};
  localparam logic [WIDTH-1:0] ZERO = '0;
  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // an event in the clearing cycle opens the new interval with one
  always_comb
  begin
    next_count = count;
    if (clr_i)
    begin
      next_count = inc_i ? ONE : ZERO;
    end
    else if (inc_i && (count != MAX_COUNT))
    begin
      next_count = count + ONE;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      count <= ZERO;
    end
    else
    begin
      count <= next_count;
    end
  end

  assign count_o = count;

endmodule

// >>> mtsc_byte_counter.sv
`timescale 1ns/1ps
module mtsc_byte_counter #(
  parameter int LEN_WIDTH = mtsc_pkg::MTSC_FRAME_LEN_WIDTH
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // received frame length
  input wire logic add_i,
  input wire logic [LEN_WIDTH-1:0] len_i,
  // host reads
  input wire logic rd_low_i,
  input wire logic rd_high_i,
  // values
  output logic [mtsc_pkg::MTSC_RX_BYTE_LOW_WIDTH-1:0] low_o,
  output logic [mtsc_pkg::MTSC_RX_BYTE_HIGH_WIDTH-1:0] high_o
);

  localparam int CW = mtsc_pkg::MTSC_RX_BYTE_WIDTH;
  localparam int LW = mtsc_pkg::MTSC_RX_BYTE_LOW_WIDTH;
  localparam int HW = mtsc_pkg::MTSC_RX_BYTE_HIGH_WIDTH;

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [CW-1:0] snap;
  logic [CW-1:0] next_snap;
  logic low_seen;
  logic next_low_seen;
  logic [CW-1:0] add_val;

  assign add_val = add_i ? CW'(len_i) : '0;

  always_comb
  begin
    next_count = count + add_val;
    next_snap = snap;
    next_low_seen = low_seen;
    if (rd_low_i)
    begin
      // whole value is frozen so the later clear removes exactly what was shown
      next_snap = count;
      next_low_seen = 1'b1;
    end
    else if (rd_high_i && low_seen)
    begin
      // subtracting instead of zeroing keeps bytes that arrived between the two reads
      next_count = count - snap + add_val;
      next_snap = '0;
      next_low_seen = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      count <= '0;
      snap <= '0;
      low_seen <= 1'b0;
    end
    else
    begin
      count <= next_count;
      snap <= next_snap;
      low_seen <= next_low_seen;
    end
  end

  assign low_o = count[LW-1:0];
  assign high_o = snap[CW-1:LW];

endmodule

// >>> mtsc_stat_counters.sv
`timescale 1ns/1ps
// Contract
// - deferred-transmit field is 18 bits, counts frames sent after deferral
// - deferred-transmit count saturates at its maximum, never wraps
// - deferred, carrier-loss and good-frame counts return value then clear on read
// - carrier-loss field is 10 bits, counts frames with carrier dropped or absent
// - carrier-loss count saturates at its maximum, never wraps
// - byte count adds whole frame length, destination address through checksum
// - byte count is 48 bits and wraps to zero past its maximum
// - reading low word latches upper bits into high word for a snapshot
// - high word shows upper 16 bits in low half, upper half reads zero
// - byte count subtracts the low-read snapshot only when a high word read follows a low word read
// - good-frame count is 32 bits, counts frames received without error
// - good-frame count saturates at its maximum, never wraps
module mtsc_stat_counters (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register read port
  input wire logic rd_stb_i,
  input wire logic [3:0] rd_memory_map_selector_i,
  input wire logic [15:0] rd_addr_i,
  output logic [31:0] rd_data_o,
  output logic rd_ack_o,
  output logic rd_hit_o,
  // mac transmit events
  input wire logic tx_deferred_frame_i,
  input wire logic tx_carrier_loss_frame_i,
  // mac receive events
  input wire logic rx_frame_done_i,
  input wire logic [mtsc_pkg::MTSC_FRAME_LEN_WIDTH-1:0] rx_frame_len_i,
  input wire logic rx_frame_ok_i
);

  logic [mtsc_pkg::MTSC_DEFERRED_TX_WIDTH-1:0] deferred_cnt;
  logic [mtsc_pkg::MTSC_CARRIER_LOSS_WIDTH-1:0] carrier_cnt;
  logic [mtsc_pkg::MTSC_GOOD_FRAME_WIDTH-1:0] good_cnt;
  logic [mtsc_pkg::MTSC_RX_BYTE_LOW_WIDTH-1:0] byte_low;
  logic [mtsc_pkg::MTSC_RX_BYTE_HIGH_WIDTH-1:0] byte_high;

  logic page_hit;
  logic rd_deferred;
  logic rd_carrier;
  logic rd_byte_low;
  logic rd_byte_high;
  logic rd_good;
  logic [31:0] read_mux;
  logic mapped;

  logic [31:0] rd_data;
  logic [31:0] next_rd_data;
  logic rd_ack;
  logic next_rd_ack;
  logic rd_hit;
  logic next_rd_hit;

  assign page_hit = rd_stb_i && (rd_memory_map_selector_i == mtsc_pkg::MTSC_MEMORY_MAP_SELECTOR);

  // address decode and read data, every field zero-extended
  always_comb
  begin
    rd_deferred = 1'b0;
    rd_carrier = 1'b0;
    rd_byte_low = 1'b0;
    rd_byte_high = 1'b0;
    rd_good = 1'b0;
    mapped = 1'b1;
    read_mux = mtsc_pkg::MTSC_UNMAPPED_DATA;
    if (!page_hit)
    begin
      mapped = 1'b0;
    end
    else if (rd_addr_i == mtsc_pkg::MTSC_DEFERRED_TX_FRAME_COUNT_ADDR)
    begin
      rd_deferred = 1'b1;
      read_mux = 32'(deferred_cnt);
    end
    else if (rd_addr_i == mtsc_pkg::MTSC_TX_CARRIER_LOSS_COUNT_ADDR)
    begin
      rd_carrier = 1'b1;
      read_mux = 32'(carrier_cnt);
    end
    else if (rd_addr_i == mtsc_pkg::MTSC_RX_BYTE_COUNT_LOW_ADDR)
    begin
      rd_byte_low = 1'b1;
      read_mux = byte_low;
    end
    else if (rd_addr_i == mtsc_pkg::MTSC_RX_BYTE_COUNT_HIGH_ADDR)
    begin
      rd_byte_high = 1'b1;
      read_mux = 32'(byte_high);
    end
    else if (rd_addr_i == mtsc_pkg::MTSC_RX_GOOD_FRAME_COUNT_ADDR)
    begin
      rd_good = 1'b1;
      read_mux = good_cnt;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  // data is sampled before the clear lands, so the host sees the old count
  always_comb
  begin
    next_rd_ack = rd_stb_i;
    next_rd_hit = mapped;
    next_rd_data = rd_stb_i ? read_mux : rd_data;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_data <= mtsc_pkg::MTSC_REG_RESET;
      rd_ack <= 1'b0;
      rd_hit <= 1'b0;
    end
    else
    begin
      rd_data <= next_rd_data;
      rd_ack <= next_rd_ack;
      rd_hit <= next_rd_hit;
    end
  end

  assign rd_data_o = rd_data;
  assign rd_ack_o = rd_ack;
  assign rd_hit_o = rd_hit;

  mtsc_sat_counter #(
    .WIDTH(mtsc_pkg::MTSC_DEFERRED_TX_WIDTH)
  ) u_deferred (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .inc_i(tx_deferred_frame_i),
    .clr_i(rd_deferred),
    .count_o(deferred_cnt)
  );

  mtsc_sat_counter #(
    .WIDTH(mtsc_pkg::MTSC_CARRIER_LOSS_WIDTH)
  ) u_carrier (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .inc_i(tx_carrier_loss_frame_i),
    .clr_i(rd_carrier),
    .count_o(carrier_cnt)
  );

  mtsc_sat_counter #(
    .WIDTH(mtsc_pkg::MTSC_GOOD_FRAME_WIDTH)
  ) u_good (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .inc_i(rx_frame_ok_i),
    .clr_i(rd_good),
    .count_o(good_cnt)
  );

  // high word is only meaningful after a low read, as the host must order them
  mtsc_byte_counter #(
    .LEN_WIDTH(mtsc_pkg::MTSC_FRAME_LEN_WIDTH)
  ) u_bytes (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .add_i(rx_frame_done_i),
    .len_i(rx_frame_len_i),
    .rd_low_i(rd_byte_low),
    .rd_high_i(rd_byte_high),
    .low_o(byte_low),
    .high_o(byte_high)
  );

endmodule

// >>> mtsc_stat_counters_sva.sv
`timescale 1ns/1ps
module mtsc_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // read port and events
  input wire logic rd_stb_i,
  input wire logic [3:0] rd_memory_map_selector_i,
  input wire logic [15:0] rd_addr_i,
  input wire logic [31:0] rd_data_o,
  input wire logic rd_ack_o,
  input wire logic rd_hit_o,
  input wire logic tx_deferred_frame_i
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic pg;
  logic m;
  assign pg = rd_stb_i && rd_memory_map_selector_i == 4'h1;
  assign m = pg && rd_addr_i >= 16'h003F && rd_addr_i <= 16'h0043;
  property p_ack; rd_stb_i |=> rd_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("no answer after read");
  property p_idle; !rd_stb_i |=> !rd_ack_o && $stable(rd_data_o); endproperty
  a_idle: assert property (p_idle) else $error("answer without read");
  property p_hit; m |=> rd_hit_o; endproperty
  a_hit: assert property (p_hit) else $error("mapped read not hit");
  property p_miss; rd_stb_i && !m |=> !rd_hit_o && rd_data_o == 32'h0; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read wrong");
  property p_def; pg && rd_addr_i == 16'h003F |=> rd_data_o[31:18] == 14'h0; endproperty
  a_def: assert property (p_def) else $error("deferred upper bits set");
  property p_crs; pg && rd_addr_i == 16'h0040 |=> rd_data_o[31:10] == 22'h0; endproperty
  a_crs: assert property (p_crs) else $error("carrier upper bits set");
  property p_hi; pg && rd_addr_i == 16'h0042 |=> rd_data_o[31:16] == 16'h0; endproperty
  a_hi: assert property (p_hi) else $error("high word upper half set");
  property p_clr;
    (pg && rd_addr_i == 16'h003F && !tx_deferred_frame_i) ##1 !tx_deferred_frame_i
      ##1 (pg && rd_addr_i == 16'h003F) |=> rd_data_o == 32'h0;
  endproperty
  a_clr: assert property (p_clr) else $error("deferred not cleared by read");
  c_unmapped: cover property (rd_stb_i && !m);
  c_high: cover property (pg && rd_addr_i == 16'h0042);
  c_sat: cover property (rd_hit_o && rd_data_o == 32'h0000_03FF);
endmodule
bind mtsc_stat_counters mtsc_checker i_mtsc_checker (.ref_clk_i, .rst_n_i, .rd_stb_i,
  .rd_memory_map_selector_i, .rd_addr_i, .rd_data_o, .rd_ack_o, .rd_hit_o, .tx_deferred_frame_i);

// >>> mtsc_host_model.sv
`timescale 1ns/1ps
module mtsc_host_model (
  // clock
  input wire logic ref_clk_i,
  // answer
  input wire logic [31:0] rd_data_i,
  input wire logic rd_ack_i,
  input wire logic rd_hit_i,
  // request
  output logic rd_stb_o = 1'b0,
  output logic [3:0] rd_memory_map_selector_o = 4'h0,
  output logic [15:0] rd_addr_o = 16'h0000
);
  task automatic rd(input logic [3:0] s, input logic [15:0] a, output logic [31:0] d, output logic h);
    @(negedge ref_clk_i);
    rd_stb_o = 1'b1;
    rd_memory_map_selector_o = s;
    rd_addr_o = a;
    @(negedge ref_clk_i);
    rd_stb_o = 1'b0;
    // a released address must not keep looking valid
    rd_addr_o = ~a;
    d = rd_data_i;
    h = rd_ack_i & rd_hit_i;
  endtask
endmodule

// >>> tb_mac_traffic_stat_counters.sv
`timescale 1ns/1ps
module tb_mac_traffic_stat_counters;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rd_stb;
  logic [3:0] rd_sel;
  logic [15:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ack;
  logic rd_hit;
  logic [3:0] ev_v = 4'h0;
  logic [15:0] len = 16'h0000;
  logic [31:0] d;
  logic h;
  int err_total = 0;
  int n_tests = 0;
  mtsc_stat_counters i_mtsc_stat_counters (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .rd_stb_i(rd_stb),
    .rd_memory_map_selector_i(rd_sel), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_ack_o(rd_ack),
    .rd_hit_o(rd_hit), .tx_deferred_frame_i(ev_v[0]), .tx_carrier_loss_frame_i(ev_v[1]),
    .rx_frame_done_i(ev_v[2]), .rx_frame_len_i(len), .rx_frame_ok_i(ev_v[3]));
  mtsc_host_model i_mtsc_host_model (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data), .rd_ack_i(rd_ack),
    .rd_hit_i(rd_hit), .rd_stb_o(rd_stb), .rd_memory_map_selector_o(rd_sel), .rd_addr_o(rd_addr));
  initial forever #25 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // single-bit results: hit flag and answer strobe
  task automatic chk_hit(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  // rd_ack still stands here, it drops only at the next rising edge
  task automatic rc(input logic [3:0] s, input logic [15:0] a, input logic [31:0] e, input logic eh);
    i_mtsc_host_model.rd(s, a, d, h);
    chk($sformatf("reg_%h", a), e, d);
    chk_hit("hit", eh, h);
    chk_hit("ack", 1'b1, rd_ack);
  endtask
  // hold one event line high for n cycles, each cycle counts once until a saturating counter reaches its maximum
  task automatic ev(input int k, input int n);
    @(negedge ref_clk_i);
    ev_v = 4'h1 << k;
    repeat (n) @(negedge ref_clk_i);
    ev_v = 4'h0;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (80000) @(posedge ref_clk_i);
    err_total++;
    report_and_stop;
  end
  initial
  begin
    repeat (5) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    for (int a = 16'h003F; a <= 16'h0043; a++)
      rc(4'h1, a[15:0], 32'h0, 1'b1);
    rc(4'h1, 16'h0044, 32'h0, 1'b0);
    rc(4'h0, 16'h003F, 32'h0, 1'b0);
    ev(0, 3);
    rc(4'h1, 16'h003F, 32'h3, 1'b1);
    fork
      rc(4'h1, 16'h003F, 32'h0, 1'b1);
      ev(0, 1);
    join
    rc(4'h1, 16'h003F, 32'h1, 1'b1);
    rc(4'h1, 16'h003F, 32'h0, 1'b1);
    ev(1, 1030);
    rc(4'h1, 16'h0040, 32'h3FF, 1'b1);
    rc(4'h1, 16'h0040, 32'h0, 1'b1);
    ev(3, 2);
    rc(4'h1, 16'h0043, 32'h2, 1'b1);
    len = 16'hFFFF;
    ev(2, 65538);
    rc(4'h1, 16'h0041, 32'h0000_FFFE, 1'b1);
    len = 16'h0040;
    ev(2, 1);
    rc(4'h1, 16'h0042, 32'h1, 1'b1);
    rc(4'h1, 16'h0041, 32'h40, 1'b1);
    report_and_stop;
  end
endmodule
